// ---- cpi_cfg.svh ----
// register offsets, field positions, reset values of the interrupt block
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH

`define CPI_OFF_CTRL 8'h00
`define CPI_OFF_FLAGS 8'h04
`define CPI_OFF_STATUS 8'h08
`define CPI_OFF_RT_RATE 8'h0C
`define CPI_OFF_AUTO_CTRL 8'h10
`define CPI_OFF_AUTO_PERIOD 8'h14

// control register fields
`define CPI_CTRL_RT_SRC 8
`define CPI_CTRL_PSEUDO 9
`define CPI_CTRL_XTAL_EN 10
`define CPI_CTRL_RT_STOP_RUN 11

// auto timer control fields
`define CPI_AUTO_EN 0
`define CPI_AUTO_CLK 1
`define CPI_AUTO_PIN 2

// flag/enable bit indices
`define CPI_NSRC 6
`define CPI_SRC_RT 0
`define CPI_SRC_PLL 1
`define CPI_SRC_XTAL 2
`define CPI_SRC_LOW 3
`define CPI_SRC_TEMP 4
`define CPI_SRC_AUTO 5

`define CPI_RT_RATE_RST 16'hFFFF
`define CPI_AUTO_PERIOD_RST 16'h0000

`define CPI_RESP_OKAY 2'h0
`define CPI_RESP_SLVERR 2'h2

`endif

// ---- cpi_pkg.sv ----
// types shared by the clock/power interrupt block
package cpi_pkg;

  // analog monitor and status inputs
  typedef struct packed {
    logic pll_lock;
    logic crystal_ready;
    logic stop_mode;
    logic full_stop;
    logic full_performance_mode;
    logic supply_below;
    logic supply_above;
    logic temp_above;
    logic temp_below;
  } cpi_mon_t;

  // one-cycle ticks of the slow timer clocks
  typedef struct packed {
    logic internal_rc_clock;
    logic crystal_clock;
    logic auto_rc_clock;
    logic bus_clock_on;
  } cpi_tick_t;

  // software control bits
  typedef struct packed {
    logic rt_clock_source_select;
    logic pseudo_stop_select;
    logic crystal_enable;
    logic rt_run_in_stop;
  } cpi_ctrl_t;

  // auto timer control
  typedef struct packed {
    logic auto_timer_pin_output_enable;
    logic auto_timer_clock_select;
    logic auto_timer_enable;
  } cpi_auto_t;

endpackage : cpi_pkg

// ---- cpi_irq.sv ----
// interrupt flags, real-time and autonomous timers with AXI4-Lite slave
// Function
// - real-time timer counts internal RC or crystal ticks by source select
// - in stop, real-time counter runs only with pseudo-stop, crystal, run bit
// - period end sets real-time flag and restarts immediately
// - any write to real-time rate register restarts the period
// - real-time request only while its enable is set
// - lock change in either direction sets flag; write one clears
// - crystal good stays zero while disabled; needs PLL lock first
// - any crystal good change sets crystal change flag
// - losing PLL lock also clears crystal good
// - crystal change request passes only with its enable
// - in full performance, low supply status follows monitor levels
// - low supply status change sets flag; request needs enable
// - in full performance, over-temp status follows monitor levels
// - over-temp status change sets flag; request needs enable
// - setting auto enable starts timer for 16-bit period
// - auto clock is RC or bus; select writable only while disabled
// - auto period writable only while disabled, else write ignored
// - auto period end sets flag, restarts; request needs enable
// - auto timer freezes when on bus clock and bus clock off
// - enable plus pin enable drives timer waveform to pin
`include "cpi_cfg.svh"

module cpi_irq
  import cpi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitors and clock ticks
  input wire cpi_mon_t mon,
  input wire cpi_tick_t tick,
  // requests toward the cpu and waveform pin
  output logic [5:0] irq_req,
  output logic auto_timer_waveform_pin
);

  logic [5:0] irq_enable_q;
  cpi_ctrl_t ctrl_q;
  cpi_auto_t auto_q;
  logic [15:0] rt_rate_register_q;
  logic [15:0] auto_timer_period_q;
  logic [5:0] flag_q;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [15:0] rt_cnt_q;
  logic [15:0] auto_cnt_q;
  logic lock_q;
  logic crystal_good_status_q;
  logic crystal_good_d;
  logic low_supply_q;
  logic over_temp_status_q;
  logic pin_q;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic wr_hit;
  logic rt_tick;
  logic rt_run;
  logic rt_end;
  logic auto_tick;
  logic auto_end;

  // byte-lane mask from write strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  assign wval = s_axi_wdata & wmask;

  // write taken when address and data both present
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_comb begin
    wr_hit = 1'b1;
    if (s_axi_awaddr == `CPI_OFF_CTRL) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `CPI_OFF_FLAGS) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `CPI_OFF_STATUS) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `CPI_OFF_RT_RATE) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `CPI_OFF_AUTO_CTRL) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `CPI_OFF_AUTO_PERIOD) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPI_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `CPI_RESP_OKAY : `CPI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // interrupt enables, low byte of the control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_q <= 6'h00;
    end else if (wr_go && s_axi_wstrb[0]
                 && s_axi_awaddr == `CPI_OFF_CTRL) begin
      irq_enable_q <= s_axi_wdata[5:0];
    end
  end

  // clock source and stop-mode control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (wr_go && s_axi_wstrb[1]
                 && s_axi_awaddr == `CPI_OFF_CTRL) begin
      ctrl_q.rt_clock_source_select <= s_axi_wdata[`CPI_CTRL_RT_SRC];
      ctrl_q.pseudo_stop_select <= s_axi_wdata[`CPI_CTRL_PSEUDO];
      ctrl_q.crystal_enable <= s_axi_wdata[`CPI_CTRL_XTAL_EN];
      ctrl_q.rt_run_in_stop <= s_axi_wdata[`CPI_CTRL_RT_STOP_RUN];
    end
  end

  // real-time rate register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rt_rate_register_q <= `CPI_RT_RATE_RST;
    end else if (wr_go && s_axi_awaddr == `CPI_OFF_RT_RATE) begin
      rt_rate_register_q <= (rt_rate_register_q & ~wmask[15:0])
                            | wval[15:0];
    end
  end

  // auto timer control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_q <= '0;
    end else if (wr_go && s_axi_wstrb[0]
                 && s_axi_awaddr == `CPI_OFF_AUTO_CTRL) begin
      auto_q.auto_timer_enable <= s_axi_wdata[`CPI_AUTO_EN];
      auto_q.auto_timer_pin_output_enable <= s_axi_wdata[`CPI_AUTO_PIN];
      if (!auto_q.auto_timer_enable) begin
        auto_q.auto_timer_clock_select <= s_axi_wdata[`CPI_AUTO_CLK];
      end
    end
  end

  // auto period, locked while the timer runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_timer_period_q <= `CPI_AUTO_PERIOD_RST;
    end else if (wr_go && !auto_q.auto_timer_enable
                 && s_axi_awaddr == `CPI_OFF_AUTO_PERIOD) begin
      auto_timer_period_q <= (auto_timer_period_q & ~wmask[15:0])
                             | wval[15:0];
    end
  end

  // real-time timer
  assign rt_tick = ctrl_q.rt_clock_source_select ?
                   tick.crystal_clock : tick.internal_rc_clock;
  assign rt_run = !mon.stop_mode
                  || (ctrl_q.pseudo_stop_select
                      && ctrl_q.rt_clock_source_select
                      && ctrl_q.rt_run_in_stop);
  assign rt_end = rt_tick && rt_run && rt_cnt_q == rt_rate_register_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rt_cnt_q <= 16'h0000;
    end else if (wr_go && s_axi_awaddr == `CPI_OFF_RT_RATE) begin
      rt_cnt_q <= 16'h0000;
    end else if (rt_end) begin
      rt_cnt_q <= 16'h0000;
    end else if (rt_tick && rt_run) begin
      rt_cnt_q <= rt_cnt_q + 16'h0001;
    end
  end

  // autonomous timer
  assign auto_tick = auto_q.auto_timer_clock_select ?
                     tick.bus_clock_on : tick.auto_rc_clock;
  assign auto_end = auto_q.auto_timer_enable && auto_tick
                    && auto_cnt_q == auto_timer_period_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_cnt_q <= 16'h0000;
    end else if (!auto_q.auto_timer_enable) begin
      auto_cnt_q <= 16'h0000;
    end else if (auto_end) begin
      auto_cnt_q <= 16'h0000;
    end else if (auto_tick) begin
      auto_cnt_q <= auto_cnt_q + 16'h0001;
    end
  end

  // waveform toggles each period while routed to the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else if (!(auto_q.auto_timer_enable
                   && auto_q.auto_timer_pin_output_enable)) begin
      pin_q <= 1'b0;
    end else if (auto_end) begin
      pin_q <= ~pin_q;
    end
  end

  assign auto_timer_waveform_pin = pin_q;

  // status tracking
  // good rises only once the registered lock is already up
  assign crystal_good_d = ctrl_q.crystal_enable && lock_q && mon.pll_lock
                          && mon.crystal_ready && !mon.full_stop;

  // registered lock status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= mon.pll_lock;
    end
  end

  // registered crystal good status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_good_status_q <= 1'b0;
    end else begin
      crystal_good_status_q <= crystal_good_d;
    end
  end

  // low supply level, updated only in full performance mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_supply_q <= 1'b0;
    end else if (mon.full_performance_mode) begin
      if (mon.supply_below) begin
        low_supply_q <= 1'b1;
      end else if (mon.supply_above) begin
        low_supply_q <= 1'b0;
      end
    end
  end

  // over-temp level, updated only in full performance mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_temp_status_q <= 1'b0;
    end else if (mon.full_performance_mode) begin
      if (mon.temp_above) begin
        over_temp_status_q <= 1'b1;
      end else if (mon.temp_below) begin
        over_temp_status_q <= 1'b0;
      end
    end
  end

  // flag set events
  always_comb begin
    flag_set = 6'h00;
    flag_set[`CPI_SRC_RT] = rt_end;
    flag_set[`CPI_SRC_PLL] = lock_q != mon.pll_lock;
    flag_set[`CPI_SRC_XTAL] = crystal_good_status_q != crystal_good_d;
    flag_set[`CPI_SRC_LOW] = mon.full_performance_mode
      && ((mon.supply_below && !low_supply_q)
          || (!mon.supply_below && mon.supply_above
              && low_supply_q));
    flag_set[`CPI_SRC_TEMP] = mon.full_performance_mode
      && ((mon.temp_above && !over_temp_status_q)
          || (!mon.temp_above && mon.temp_below
              && over_temp_status_q));
    flag_set[`CPI_SRC_AUTO] = auto_end;
  end

  assign flag_clr = (wr_go && s_axi_awaddr == `CPI_OFF_FLAGS) ?
                    wval[5:0] : 6'h00;

  // set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 6'h00;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // requests held while flag and enable both set
  assign irq_req = flag_q & irq_enable_q;

  // read data select
  always_comb begin
    rdata_d = 32'h0000_0000;
    rresp_d = `CPI_RESP_OKAY;
    if (s_axi_araddr == `CPI_OFF_CTRL) begin
      rdata_d[5:0] = irq_enable_q;
      rdata_d[`CPI_CTRL_RT_SRC] = ctrl_q.rt_clock_source_select;
      rdata_d[`CPI_CTRL_PSEUDO] = ctrl_q.pseudo_stop_select;
      rdata_d[`CPI_CTRL_XTAL_EN] = ctrl_q.crystal_enable;
      rdata_d[`CPI_CTRL_RT_STOP_RUN] = ctrl_q.rt_run_in_stop;
    end else if (s_axi_araddr == `CPI_OFF_FLAGS) begin
      rdata_d[5:0] = flag_q;
    end else if (s_axi_araddr == `CPI_OFF_STATUS) begin
      rdata_d[0] = lock_q;
      rdata_d[1] = crystal_good_status_q;
      rdata_d[2] = low_supply_q;
      rdata_d[3] = over_temp_status_q;
    end else if (s_axi_araddr == `CPI_OFF_RT_RATE) begin
      rdata_d[15:0] = rt_rate_register_q;
    end else if (s_axi_araddr == `CPI_OFF_AUTO_CTRL) begin
      rdata_d[`CPI_AUTO_EN] = auto_q.auto_timer_enable;
      rdata_d[`CPI_AUTO_CLK] = auto_q.auto_timer_clock_select;
      rdata_d[`CPI_AUTO_PIN] = auto_q.auto_timer_pin_output_enable;
    end else if (s_axi_araddr == `CPI_OFF_AUTO_PERIOD) begin
      rdata_d[15:0] = auto_timer_period_q;
    end else begin
      rresp_d = `CPI_RESP_SLVERR;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CPI_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : cpi_irq

// ---- cpi_cpu_model.sv ----
// cpu side model: global mask and capture of requests
module cpi_cpu_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests in, accepted requests out
  input wire logic [5:0] irq_req,
  input wire logic global_mask,
  output logic [5:0] taken_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // a masked cpu sees nothing, an open one every level request
  always_ff @(posedge aclk) begin
    if (!aresetn) taken_q <= 6'h00;
    else taken_q <= global_mask ? 6'h00 : irq_req;
  end
endmodule : cpi_cpu_model

// ---- cpi_chk.sv ----
// assertions on the ports of the interrupt block
module cpi_chk
  import cpi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitors, ticks, requests
  input wire cpi_mon_t mon,
  input wire cpi_tick_t tick,
  input wire logic [5:0] irq_req,
  input wire logic auto_timer_waveform_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_tk;
  assign wr_tk = s_axi_awvalid & s_axi_awready;

  a_write_answer: assert property (wr_tk |=> s_axi_bvalid)
    else $error("no write response");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_no_stray_b: assert property ($rose(s_axi_bvalid) |-> $past(wr_tk))
    else $error("stray write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read response");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_irq_fall_write: assert property (|(~irq_req & $past(irq_req)) |->
    $past(wr_tk)) else $error("request fell without write");
  a_rt_rise_tick: assert property ($rose(irq_req[0]) |-> $past(wr_tk ||
    tick.internal_rc_clock || tick.crystal_clock))
    else $error("rt request without tick");
  a_auto_rise_tick: assert property ($rose(irq_req[5]) |-> $past(wr_tk ||
    tick.auto_rc_clock || tick.bus_clock_on))
    else $error("auto request without tick");
  a_mon_rise_fpm: assert property ($rose(irq_req[3]) || $rose(irq_req[4])
    |-> $past(wr_tk || mon.full_performance_mode))
    else $error("monitor request outside fpm");
  a_pin_change: assert property ($changed(auto_timer_waveform_pin) |->
    $past(wr_tk || tick.auto_rc_clock || tick.bus_clock_on))
    else $error("pin moved without tick");
endmodule : cpi_chk

bind cpi_irq cpi_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mon, .tick, .irq_req,
  .auto_timer_waveform_pin);

// ---- cpi_tb.sv ----
// self-checking bench for the clock/power interrupt block
`include "cpi_cfg.svh"
module testbench
  import cpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, mask = 1'b0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [3:0] ws = 4'hF;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, pin;
  logic [1:0] br, rr, bres, rres;
  logic [31:0] rdq;
  logic [5:0] irq, taken;
  cpi_mon_t mon = '0;
  cpi_tick_t tick = '0;
  int error_cnt = 0, cmp_count = 0;

  cpi_irq uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdq), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .mon(mon), .tick(tick), .irq_req(irq),
    .auto_timer_waveform_pin(pin));
  cpi_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .irq_req(irq),
    .global_mask(mask), .taken_q(taken));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic lim(input int n);
    if (n >= 40) begin
      error_cnt++;
      $display("mismatch timeout expected answer seen none");
      wrap_up();
    end
  endtask : lim

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy

  // address and data offered together, bready raised a cycle late
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (awr !== 1'b1 && n < 40);
    chk("wready", 32'h1, wrd);
    awv <= 1'b0; wv <= 1'b0;
    @(posedge aclk);
    brdy <= 1'b1;
    do begin @(posedge aclk); n++; end while (bv !== 1'b1 && n < 40);
    bres = br; brdy <= 1'b0;
    lim(n);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    ara <= a; arv <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (arr !== 1'b1 && n < 40);
    arv <= 1'b0;
    @(posedge aclk);
    rrdy <= 1'b1;
    do begin @(posedge aclk); n++; end while (rv !== 1'b1 && n < 40);
    rdat = rdq; rres = rr; rrdy <= 1'b0;
    lim(n);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
    rd(a);
    chk(n, e, rdat);
  endtask : rc

  // one-cycle slow-clock ticks on tick bit b
  task automatic tk(input int b, input int n);
    repeat (n) begin
      tick[b] <= 1'b1; @(posedge aclk);
      tick[b] <= 1'b0; @(posedge aclk);
    end
  endtask : tk

  initial begin
    cy(5);
    aresetn <= 1'b1;
    cy(1);
    rc(`CPI_OFF_CTRL, 32'h0, "ctrl");
    rc(`CPI_OFF_RT_RATE, 32'h0000FFFF, "rt rate");
    rc(`CPI_OFF_AUTO_PERIOD, 32'h0, "auto period");
    rc(8'h20, 32'h0, "unmapped read");
    chk("rresp", `CPI_RESP_SLVERR, rres);
    wr(8'h20, 32'h1);
    chk("bresp", `CPI_RESP_SLVERR, bres);
    ws <= 4'h1; wr(`CPI_OFF_RT_RATE, 32'h1234); ws <= 4'hF;
    rc(`CPI_OFF_RT_RATE, 32'h0000FF34, "byte lane");
    $display("done reset and bus");
    wr(`CPI_OFF_CTRL, 32'h3F);
    wr(`CPI_OFF_RT_RATE, 32'h2);
    tk(3, 2); chk("rt early", 32'h0, irq);
    tk(3, 1); chk("rt irq", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h0); chk("rt zero write", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h1); chk("rt clear", 32'h0, irq);
    tk(3, 3); chk("rt restart", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h1); tk(3, 2);
    wr(`CPI_OFF_RT_RATE, 32'h2); tk(3, 2); chk("rt rewrite", 32'h0, irq);
    tk(3, 1); chk("rt rewrite end", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h1); wr(`CPI_OFF_CTRL, 32'h13F);
    tk(3, 3); chk("rt wrong src", 32'h0, irq);
    tk(2, 3); chk("rt crystal", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h1); mon.stop_mode <= 1'b1;
    tk(2, 3); chk("rt stop halt", 32'h0, irq);
    wr(`CPI_OFF_CTRL, 32'hB3F); tk(2, 3); chk("rt stop run", 32'h1, irq);
    wr(`CPI_OFF_FLAGS, 32'h1); mon.stop_mode <= 1'b0;
    wr(`CPI_OFF_CTRL, 32'h3E); tk(3, 3); chk("rt masked", 32'h0, irq);
    rc(`CPI_OFF_FLAGS, 32'h1, "rt flag");
    wr(`CPI_OFF_FLAGS, 32'h1);
    $display("done real-time timer");
    mon.pll_lock <= 1'b1; cy(2); chk("lock rise", 32'h2, irq);
    wr(`CPI_OFF_FLAGS, 32'h2); mon.pll_lock <= 1'b0;
    cy(2); chk("lock fall", 32'h2, irq);
    wr(`CPI_OFF_FLAGS, 32'h2); mon.crystal_ready <= 1'b1;
    cy(2); rc(`CPI_OFF_STATUS, 32'h0, "good off");
    wr(`CPI_OFF_CTRL, 32'h43E); cy(2); rc(`CPI_OFF_STATUS, 32'h0, "no lock");
    mon.pll_lock <= 1'b1; cy(2); rc(`CPI_OFF_STATUS, 32'h3, "good");
    chk("good irq", 32'h6, irq);
    wr(`CPI_OFF_FLAGS, 32'h3F); mon.pll_lock <= 1'b0; cy(2);
    rc(`CPI_OFF_STATUS, 32'h0, "lock lost");
    chk("lost irq", 32'h6, irq);
    wr(`CPI_OFF_FLAGS, 32'h3F); wr(`CPI_OFF_CTRL, 32'h43A);
    mon.pll_lock <= 1'b1; cy(2); chk("xtal masked", 32'h2, irq);
    rc(`CPI_OFF_FLAGS, 32'h6, "xtal flag");
    wr(`CPI_OFF_FLAGS, 32'h3F); mon.full_stop <= 1'b1;
    cy(2); rc(`CPI_OFF_FLAGS, 32'h4, "full stop");
    mon.full_stop <= 1'b0; cy(2); wr(`CPI_OFF_FLAGS, 32'h3F);
    wr(`CPI_OFF_CTRL, 32'h3F); cy(2); rc(`CPI_OFF_FLAGS, 32'h4, "disable");
    wr(`CPI_OFF_FLAGS, 32'h3F);
    $display("done lock and crystal");
    mon.supply_below <= 1'b1; cy(2);
    rc(`CPI_OFF_STATUS, 32'h1, "low outside fpm");
    mon.full_performance_mode <= 1'b1; cy(2);
    rc(`CPI_OFF_STATUS, 32'h5, "low set");
    chk("low irq", 32'h8, irq);
    wr(`CPI_OFF_FLAGS, 32'h8);
    mon.supply_below <= 1'b0; mon.supply_above <= 1'b1; cy(2);
    rc(`CPI_OFF_STATUS, 32'h1, "low clear");
    chk("low clr irq", 32'h8, irq);
    mon.temp_above <= 1'b1; cy(2);
    rc(`CPI_OFF_STATUS, 32'h9, "temp set");
    chk("temp irq", 32'h18, irq);
    wr(`CPI_OFF_FLAGS, 32'h18);
    mon.temp_above <= 1'b0; mon.temp_below <= 1'b1; cy(2);
    rc(`CPI_OFF_STATUS, 32'h1, "temp clear");
    wr(`CPI_OFF_CTRL, 32'h2F); chk("temp masked", 32'h0, irq);
    wr(`CPI_OFF_CTRL, 32'h3F); wr(`CPI_OFF_FLAGS, 32'h3F);
    $display("done monitors");
    wr(`CPI_OFF_AUTO_PERIOD, 32'h1); wr(`CPI_OFF_AUTO_CTRL, 32'h5);
    wr(`CPI_OFF_AUTO_PERIOD, 32'h7);
    rc(`CPI_OFF_AUTO_PERIOD, 32'h1, "period locked");
    wr(`CPI_OFF_AUTO_CTRL, 32'h7);
    rc(`CPI_OFF_AUTO_CTRL, 32'h5, "clk locked");
    tk(1, 1); chk("auto early", 32'h0, irq);
    tk(1, 1); chk("auto irq", 32'h20, irq);
    chk("pin up", 32'h1, pin);
    mask <= 1'b1; cy(2); chk("cpu masked", 32'h0, taken);
    mask <= 1'b0; cy(2); chk("cpu taken", 32'h20, taken);
    wr(`CPI_OFF_FLAGS, 32'h20); tk(1, 2); chk("auto again", 32'h20, irq);
    chk("pin down", 32'h0, pin);
    wr(`CPI_OFF_FLAGS, 32'h20); cy(2); chk("cpu clear", 32'h0, taken);
    wr(`CPI_OFF_AUTO_CTRL, 32'h0);
    wr(`CPI_OFF_AUTO_CTRL, 32'h2); wr(`CPI_OFF_AUTO_CTRL, 32'h3);
    tick.bus_clock_on <= 1'b1; cy(1); tick.bus_clock_on <= 1'b0; cy(3);
    chk("bus frozen", 32'h0, irq);
    tick.bus_clock_on <= 1'b1; cy(1); tick.bus_clock_on <= 1'b0; cy(1);
    chk("bus irq", 32'h20, irq);
    chk("pin off", 32'h0, pin);
    $display("done auto timer");
    wrap_up();
  end
endmodule : testbench
